// ---- common/pswi_pkg.sv ----
package pswi_pkg;

    // register indices on the management port
    localparam logic [7:0] PORT2_CTRL_ADDR    = 8'h2c;
    localparam logic [7:0] CENTER_CFG_ADDR    = 8'h40;
    localparam logic [7:0] CENTER_STAT_ADDR   = 8'h41;
    localparam logic [7:0] PHY_SW_INIT_ADDR   = 8'h43;
    localparam logic [7:0] LOOPBACK_SETUP_ADDR = 8'h44;

    // phy_switch_init field positions
    localparam int INIT_RATE_BIT      = 7;
    localparam int INIT_DUPLEX_BIT    = 6;
    localparam int INIT_NEGOTIATE_BIT = 5;
    localparam int INIT_FABRIC_BIT    = 4;
    localparam int INIT_REMOTE_BIT    = 3;
    localparam int INIT_PROPAGATE_BIT = 2;
    localparam int INIT_FIBER_TX_BIT  = 1;
    localparam int INIT_XCVR_BIT      = 0;

    // alias positions in the port 2 control register
    localparam int P2_NEGOTIATE_BIT = 7;
    localparam int P2_RATE_BIT      = 6;
    localparam int PORT2_DUPLEX_SELECT_BIT    = 5;

    // center status busy position
    localparam int STAT_BUSY_BIT = 7;

    // reset values, loop count limit and clear command
    localparam logic       REMOTE_RESET    = 1'b0;
    localparam logic       FIBER_TX_RESET  = 1'b0;
    localparam logic [7:0] LOOPBACK_RESET  = 8'h07;
    localparam logic [7:0] LOOPBACK_MAX    = 8'h64;
    localparam logic [7:0] LOOPBACK_CLEAR  = 8'h00;

    // strap vector positions
    localparam int STRAP_RATE      = 0;
    localparam int STRAP_DUPLEX    = 1;
    localparam int STRAP_NEGOTIATE = 2;
    localparam int STRAP_PROPAGATE = 3;
    localparam int STRAP_CENTER    = 4;
    localparam int STRAP_WIDTH     = 5;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pswi_req_t;

    typedef struct packed {
        logic       port2_rate_select;
        logic       port2_duplex_select;
        logic       port2_negotiate_enable;
        logic       soft_fabric_reset;
        logic       remote_access_enable;
        logic       fiber_tx_disable;
        logic       transceiver_reset;
        logic       copper_tx_disable;
        logic       copper_led_off;
        logic       counters_clear;
        logic       results_clear;
        logic       run_start;
        logic [7:0] run_count;
        logic       center_busy;
    } pswi_ctrl_t;

    typedef struct packed {
        pswi_ctrl_t ctrl;
        logic       link_drop_propagate;
        logic       center_mode;
        logic       xcvr_hold;
        logic [7:0] loopback_count;
        logic [7:0] rdata;
        logic       rvalid;
    } pswi_state_t;

endpackage

// ---- logic/pswi_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser per bit; no reset so straps flow during reset
module pswi_sync
#(
    parameter int WIDTH = 1
)
(
    // clock
    input  wire logic             ref_clk,
    // pins and result
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] stage1;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge ref_clk)
            begin
                stage1[i]   <= pin_in[i];
                pin_sync[i] <= stage1[i];
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ---- logic/pswi_regs.sv ----
// Summary of operation
// - port 2 speed bit, strapped, aliased
// - port 2 duplex bit, strapped, aliased
// - port 2 negotiation bit, strapped, aliased
// - fabric reset bit pulses, self-clears
// - remote command access enable, resets 0
// - terminal mode link drop kills copper
// - center mode ignores propagate; strap reset
// - fiber transmit disable tri-states port 1
// - transceiver reset bit pulses, self-clears
// - transceiver reset keeps maintenance registers
// - center mode holds transceivers until 0x40
// - zero write clears valid frame counters
// - center zero write clears result counters
// - center count 1..100 sends packets
// - loop back count resets to seven
// - busy reads one while run pending
// - center zero write clears crc error count
`timescale 1ns/10ps
`default_nettype none

module pswi_regs
(
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    // management register port
    input  wire pswi_pkg::pswi_req_t req,
    output logic [7:0]              rdata,
    output logic                    rvalid,
    // strap pins
    input  wire logic               port2_rate_strap,
    input  wire logic               port2_duplex_strap,
    input  wire logic               port2_negotiate_strap,
    input  wire logic               link_propagate_strap,
    input  wire logic               center_mode_strap,
    // link status from port logic
    input  wire logic               fiber_link_up,
    input  wire logic               far_copper_link_up,
    // loop back engine status
    input  wire logic               run_active,
    input  wire logic               reply_pending,
    // control outputs
    output pswi_pkg::pswi_ctrl_t    ctrl
);

    logic [pswi_pkg::STRAP_WIDTH-1:0] strap_pins;
    logic [pswi_pkg::STRAP_WIDTH-1:0] strap_sync;
    pswi_pkg::pswi_state_t            st;
    pswi_pkg::pswi_state_t            next_st;
    logic                             wr_init;
    logic                             wr_alias;
    logic                             wr_loop;
    logic                             wr_center_cfg;
    logic                             link_lost;
    logic [7:0]                       init_view;
    logic [7:0]                       alias_view;
    logic [7:0]                       stat_view;
    logic [7:0]                       read_view;
    logic                             loop_zero;
    logic                             loop_start;
    logic                             busy_next;
    logic                             copper_kill;

    assign strap_pins[pswi_pkg::STRAP_RATE]      = port2_rate_strap;
    assign strap_pins[pswi_pkg::STRAP_DUPLEX]    = port2_duplex_strap;
    assign strap_pins[pswi_pkg::STRAP_NEGOTIATE] = port2_negotiate_strap;
    assign strap_pins[pswi_pkg::STRAP_PROPAGATE] = link_propagate_strap;
    assign strap_pins[pswi_pkg::STRAP_CENTER]    = center_mode_strap;

    pswi_sync
    #(
        .WIDTH(pswi_pkg::STRAP_WIDTH)
    )
    u_strap_sync
    (
        .ref_clk (ref_clk),
        .pin_in  (strap_pins),
        .pin_sync(strap_sync)
    );

    // one decoder keeps the whole write map in one place
    always_comb
    begin
        wr_init       = 1'b0;
        wr_alias      = 1'b0;
        wr_loop       = 1'b0;
        wr_center_cfg = 1'b0;
        if (req.wr)
        begin
            case (req.addr)
                pswi_pkg::PHY_SW_INIT_ADDR:
                begin
                    wr_init = 1'b1;
                end
                pswi_pkg::PORT2_CTRL_ADDR:
                begin
                    wr_alias = 1'b1;
                end
                pswi_pkg::LOOPBACK_SETUP_ADDR:
                begin
                    wr_loop = 1'b1;
                end
                // any data written here ends the center hold
                pswi_pkg::CENTER_CFG_ADDR:
                begin
                    wr_center_cfg = 1'b1;
                end
                // status is read only and unmapped writes are dropped
                default:
                begin
                    wr_init = 1'b0;
                end
            endcase
        end
    end

    // link inputs come from logic on ref_clk, no synchroniser needed
    assign link_lost = !fiber_link_up || !far_copper_link_up;

    always_comb
    begin
        init_view = 8'h00;
        init_view[pswi_pkg::INIT_RATE_BIT]      = st.ctrl.port2_rate_select;
        init_view[pswi_pkg::INIT_DUPLEX_BIT]    = st.ctrl.port2_duplex_select;
        init_view[pswi_pkg::INIT_NEGOTIATE_BIT] =
            st.ctrl.port2_negotiate_enable;
        init_view[pswi_pkg::INIT_FABRIC_BIT]    = st.ctrl.soft_fabric_reset;
        init_view[pswi_pkg::INIT_REMOTE_BIT]    = st.ctrl.remote_access_enable;
        init_view[pswi_pkg::INIT_PROPAGATE_BIT] = st.link_drop_propagate;
        init_view[pswi_pkg::INIT_FIBER_TX_BIT]  = st.ctrl.fiber_tx_disable;
        init_view[pswi_pkg::INIT_XCVR_BIT]      = st.ctrl.transceiver_reset;
    end

    // only the three shared bits of the port 2 register live here
    always_comb
    begin
        alias_view = 8'h00;
        alias_view[pswi_pkg::P2_NEGOTIATE_BIT] =
            st.ctrl.port2_negotiate_enable;
        alias_view[pswi_pkg::P2_RATE_BIT]      = st.ctrl.port2_rate_select;
        alias_view[pswi_pkg::PORT2_DUPLEX_SELECT_BIT]    = st.ctrl.port2_duplex_select;
    end

    always_comb
    begin
        stat_view = 8'h00;
        stat_view[pswi_pkg::STAT_BUSY_BIT] = st.ctrl.center_busy;
    end

    // rdata is registered, so the answer stands until the next read
    always_comb
    begin
        read_view = 8'h00;
        case (req.addr)
            pswi_pkg::PHY_SW_INIT_ADDR:
            begin
                read_view = init_view;
            end
            pswi_pkg::PORT2_CTRL_ADDR:
            begin
                read_view = alias_view;
            end
            // busy sits in the center status register
            pswi_pkg::CENTER_STAT_ADDR:
            begin
                read_view = stat_view;
            end
            pswi_pkg::LOOPBACK_SETUP_ADDR:
            begin
                read_view = st.loopback_count;
            end
            // unmapped indices read as zero
            default:
            begin
                read_view = 8'h00;
            end
        endcase
    end

    // counts past the limit only store, they start nothing
    always_comb
    begin
        loop_zero  = 1'b0;
        loop_start = 1'b0;
        if (wr_loop)
        begin
            if (req.wdata == pswi_pkg::LOOPBACK_CLEAR)
            begin
                loop_zero = 1'b1;
            end
            else if (st.center_mode &&
                req.wdata <= pswi_pkg::LOOPBACK_MAX)
            begin
                loop_start = 1'b1;
            end
        end
    end

    // strobe already counts so busy has no gap before the engine
    always_comb
    begin
        busy_next = run_active || reply_pending;
        if (loop_start)
        begin
            busy_next = 1'b1;
        end
    end

    // propagation only has meaning on the terminal side
    always_comb
    begin
        copper_kill = 1'b0;
        if (!st.center_mode && st.link_drop_propagate)
        begin
            copper_kill = link_lost;
        end
    end

    always_comb
    begin
        next_st = st;

        // one-cycle strobes drop unless re-armed below
        next_st.ctrl.soft_fabric_reset = 1'b0;
        next_st.ctrl.counters_clear    = 1'b0;
        next_st.ctrl.results_clear     = 1'b0;
        next_st.ctrl.run_start         = 1'b0;
        next_st.rvalid                 = 1'b0;

        // self-clearing write pulse; center hold keeps it high
        next_st.ctrl.transceiver_reset = st.xcvr_hold;

        // register 0x40 programmed releases the power-up hold
        if (wr_center_cfg)
        begin
            next_st.xcvr_hold              = 1'b0;
            next_st.ctrl.transceiver_reset = 1'b0;
        end

        if (wr_init)
        begin
            next_st.ctrl.port2_rate_select =
                req.wdata[pswi_pkg::INIT_RATE_BIT];
            next_st.ctrl.port2_duplex_select =
                req.wdata[pswi_pkg::INIT_DUPLEX_BIT];
            next_st.ctrl.port2_negotiate_enable =
                req.wdata[pswi_pkg::INIT_NEGOTIATE_BIT];
            next_st.ctrl.soft_fabric_reset =
                req.wdata[pswi_pkg::INIT_FABRIC_BIT];
            next_st.ctrl.remote_access_enable =
                req.wdata[pswi_pkg::INIT_REMOTE_BIT];
            next_st.link_drop_propagate =
                req.wdata[pswi_pkg::INIT_PROPAGATE_BIT];
            next_st.ctrl.fiber_tx_disable =
                req.wdata[pswi_pkg::INIT_FIBER_TX_BIT];
            // writing 0 never cuts the center hold short
            if (req.wdata[pswi_pkg::INIT_XCVR_BIT])
            begin
                next_st.ctrl.transceiver_reset = 1'b1;
            end
        end

        // same flops as above, reached through the port 2 register
        if (wr_alias)
        begin
            next_st.ctrl.port2_rate_select =
                req.wdata[pswi_pkg::P2_RATE_BIT];
            next_st.ctrl.port2_duplex_select =
                req.wdata[pswi_pkg::PORT2_DUPLEX_SELECT_BIT];
            next_st.ctrl.port2_negotiate_enable =
                req.wdata[pswi_pkg::P2_NEGOTIATE_BIT];
        end

        if (wr_loop)
        begin
            next_st.loopback_count = req.wdata;
        end

        if (loop_zero)
        begin
            next_st.ctrl.counters_clear = 1'b1;
            // crc, timeout and third result counter
            next_st.ctrl.results_clear = st.center_mode;
        end

        if (loop_start)
        begin
            // every accepted write restarts, even a repeated value
            next_st.ctrl.run_start = 1'b1;
            next_st.ctrl.run_count = req.wdata;
        end

        next_st.ctrl.center_busy       = busy_next;
        next_st.ctrl.copper_tx_disable = copper_kill;
        next_st.ctrl.copper_led_off    = copper_kill;

        if (req.rd)
        begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = read_view;
        end

        // synchronous reset; straps are sampled while rstn is low
        if (!rstn)
        begin
            next_st = '0;
            next_st.ctrl.port2_rate_select =
                strap_sync[pswi_pkg::STRAP_RATE];
            next_st.ctrl.port2_duplex_select =
                strap_sync[pswi_pkg::STRAP_DUPLEX];
            next_st.ctrl.port2_negotiate_enable =
                strap_sync[pswi_pkg::STRAP_NEGOTIATE];
            next_st.ctrl.remote_access_enable = pswi_pkg::REMOTE_RESET;
            next_st.link_drop_propagate =
                strap_sync[pswi_pkg::STRAP_PROPAGATE];
            next_st.ctrl.fiber_tx_disable = pswi_pkg::FIBER_TX_RESET;
            next_st.center_mode = strap_sync[pswi_pkg::STRAP_CENTER];
            next_st.xcvr_hold = strap_sync[pswi_pkg::STRAP_CENTER];
            next_st.ctrl.transceiver_reset =
                strap_sync[pswi_pkg::STRAP_CENTER];
            next_st.loopback_count = pswi_pkg::LOOPBACK_RESET;
            next_st.ctrl.run_count = pswi_pkg::LOOPBACK_RESET;
        end
    end

    // the transceiver reset output never feeds back here, so every
    // maintenance register keeps its value across it
    always_ff @(posedge ref_clk)
    begin
        st <= next_st;
    end

    assign ctrl   = st.ctrl;
    assign rdata  = st.rdata;
    assign rvalid = st.rvalid;

endmodule

`default_nettype wire

// ---- sim/pswi_regs_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none

module pswi_regs_assertions
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    // register port and straps
    input  wire pswi_pkg::pswi_req_t  req,
    input  wire logic                 center_mode_strap,
    // status inputs
    input  wire logic                 fiber_link_up,
    input  wire logic                 far_copper_link_up,
    input  wire logic                 run_active,
    input  wire logic                 reply_pending,
    // controls
    input  wire pswi_pkg::pswi_ctrl_t ctrl
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    logic w43;
    logic w44;
    assign w43 = req.wr && req.addr == 8'h43;
    assign w44 = req.wr && req.addr == 8'h44;

    a_fabric_pulse: assert property (
        ctrl.soft_fabric_reset == $past(w43 && req.wdata[4]))
        else $error("fabric reset pulse wrong");
    a_xcvr_pulse: assert property (
        w43 && req.wdata[0] && !center_mode_strap
        |=> ctrl.transceiver_reset ##1 !ctrl.transceiver_reset)
        else $error("transceiver reset pulse wrong");
    a_remote_level: assert property (
        w43 |=> ctrl.remote_access_enable == $past(req.wdata[3]))
        else $error("remote enable not written");
    a_fiber_level: assert property (
        w43 |=> ctrl.fiber_tx_disable == $past(req.wdata[1]))
        else $error("fiber disable not written");
    a_rate_alias: assert property (
        req.wr && req.addr == 8'h2c
        |=> ctrl.port2_rate_select == $past(req.wdata[6]))
        else $error("rate alias not written");
    a_link_keep: assert property (
        $past(fiber_link_up && far_copper_link_up) || center_mode_strap
        |-> !ctrl.copper_tx_disable && !ctrl.copper_led_off)
        else $error("copper disabled without cause");
    a_run_start: assert property (
        w44 && center_mode_strap && req.wdata inside {[8'h01:8'h64]}
        |=> ctrl.run_start && ctrl.run_count == $past(req.wdata))
        else $error("run not started");
    a_no_run: assert property (
        w44 && !center_mode_strap |=> !ctrl.run_start)
        else $error("run started on terminal side");
    a_zero_clear: assert property (
        w44 && req.wdata == 8'h00
        |=> ctrl.counters_clear && ctrl.results_clear == center_mode_strap)
        else $error("zero write clear wrong");
    a_busy_follow: assert property (
        $past(run_active || reply_pending) |-> ctrl.center_busy)
        else $error("busy low while run pending");
endmodule

`default_nettype wire

// ---- sim/pswi_mgmt_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module pswi_mgmt_model
(
    // clock
    input  wire logic                ref_clk,
    // register port
    output var pswi_pkg::pswi_req_t  req,
    input  wire logic [7:0]          rdata,
    input  wire logic                rvalid
);
    initial req = '0;

    // undefined loop counts are never sent
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        req.wr    = addr != 8'h44 || data <= 8'h64;
        req.addr  = addr;
        req.wdata = data;
        @(negedge ref_clk);
        req.wr    = 1'b0;
        req.wdata = ~data;
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data,
                      output logic ok);
        @(negedge ref_clk);
        req.rd   = 1'b1;
        req.addr = addr;
        @(negedge ref_clk);
        req.rd = 1'b0;
        data   = rdata;
        ok     = rvalid;
    endtask
endmodule

`default_nettype wire

// ---- sim/pswi_regs_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module pswi_regs_tb_top;
    logic                 ref_clk = 1'b0;
    logic                 rstn = 1'b0;
    pswi_pkg::pswi_req_t  req;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 rate_s = 1'b0, dup_s = 1'b0, neg_s = 1'b0;
    logic                 prop_s = 1'b0, ctr_s = 1'b0;
    logic                 fib_up = 1'b1, far_up = 1'b1;
    logic                 run_act = 1'b0, reply = 1'b0;
    pswi_pkg::pswi_ctrl_t ctrl;
    logic [7:0]           rd_val;
    logic                 rd_ok;
    logic [7:0]           runs [3] = '{8'h01, 8'h64, 8'h64};
    int                   errors = 0;
    int                   n_compared = 0;

    always #25 ref_clk = ~ref_clk;

    pswi_mgmt_model mgmt (.ref_clk(ref_clk), .req(req), .rdata(rdata),
                          .rvalid(rvalid));
    pswi_regs uut (.ref_clk(ref_clk), .rstn(rstn), .req(req),
        .rdata(rdata), .rvalid(rvalid), .port2_rate_strap(rate_s),
        .port2_duplex_strap(dup_s), .port2_negotiate_strap(neg_s),
        .link_propagate_strap(prop_s), .center_mode_strap(ctr_s),
        .fiber_link_up(fib_up), .far_copper_link_up(far_up),
        .run_active(run_act), .reply_pending(reply), .ctrl(ctrl));

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkb(input string n, input logic e, input logic g);
        chk(n, {7'h00, e}, {7'h00, g});
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [7:0] e);
        mgmt.rd(addr, rd_val, rd_ok);
        chkb("rvalid", 1'b1, rd_ok);
        chk("rdata", e, rd_val);
    endtask

    // straps settle through the synchroniser while reset is held
    task automatic do_reset(input logic [4:0] s);
        @(negedge ref_clk);
        rstn = 1'b0;
        {ctr_s, prop_s, neg_s, dup_s, rate_s} = s;
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
    endtask

    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #100000;
        errors++;
        end_sim();
    end

    initial
    begin
        do_reset(5'b01101);
        rdchk(8'h43, 8'ha4);
        rdchk(8'h44, 8'h07);
        rdchk(8'h2c, 8'hc0);
        mgmt.wr(8'h2c, 8'h20);
        rdchk(8'h43, 8'h44);
        mgmt.wr(8'h43, 8'h1f);
        chkb("fabric", 1'b1, ctrl.soft_fabric_reset);
        chkb("xcvr", 1'b1, ctrl.transceiver_reset);
        chkb("remote", 1'b1, ctrl.remote_access_enable);
        chkb("fiber", 1'b1, ctrl.fiber_tx_disable);
        rdchk(8'h43, 8'h0e);
        rdchk(8'h44, 8'h07);
        fib_up = 1'b0;
        @(negedge ref_clk);
        chkb("tx off", 1'b1, ctrl.copper_tx_disable);
        fib_up = 1'b1;
        far_up = 1'b0;
        @(negedge ref_clk);
        chkb("led off", 1'b1, ctrl.copper_led_off);
        mgmt.wr(8'h43, 8'h00);
        // copper outputs follow the stored propagate bit one cycle later
        @(negedge ref_clk);
        chkb("tx off", 1'b0, ctrl.copper_tx_disable);
        chkb("led off", 1'b0, ctrl.copper_led_off);
        far_up = 1'b1;
        mgmt.wr(8'h44, 8'h05);
        chkb("run", 1'b0, ctrl.run_start);
        rdchk(8'h44, 8'h05);
        mgmt.wr(8'h44, 8'h00);
        chkb("cnt clr", 1'b1, ctrl.counters_clear);
        chkb("res clr", 1'b0, ctrl.results_clear);
        do_reset(5'b10010);
        chkb("hold", 1'b1, ctrl.transceiver_reset);
        rdchk(8'h43, 8'h41);
        rdchk(8'h2c, 8'h20);
        mgmt.wr(8'h43, 8'h44);
        fib_up = 1'b0;
        chkb("hold", 1'b1, ctrl.transceiver_reset);
        mgmt.wr(8'h40, 8'h01);
        chkb("hold", 1'b0, ctrl.transceiver_reset);
        chkb("tx off", 1'b0, ctrl.copper_tx_disable);
        fib_up = 1'b1;
        foreach (runs[i])
        begin
            mgmt.wr(8'h44, runs[i]);
            chkb("run", 1'b1, ctrl.run_start);
            chk("count", runs[i], ctrl.run_count);
            chkb("busy", 1'b1, ctrl.center_busy);
        end
        @(negedge ref_clk);
        chkb("busy", 1'b0, ctrl.center_busy);
        reply = 1'b1;
        @(negedge ref_clk);
        chkb("busy", 1'b1, ctrl.center_busy);
        rdchk(8'h41, 8'h80);
        reply = 1'b0;
        run_act = 1'b1;
        @(negedge ref_clk);
        chkb("busy", 1'b1, ctrl.center_busy);
        run_act = 1'b0;
        mgmt.wr(8'h44, 8'h00);
        chkb("cnt clr", 1'b1, ctrl.counters_clear);
        chkb("res clr", 1'b1, ctrl.results_clear);
        rdchk(8'h99, 8'h00);
        end_sim();
    end
endmodule

bind pswi_regs pswi_regs_assertions chk (.ref_clk(ref_clk), .rstn(rstn),
    .req(req), .center_mode_strap(center_mode_strap),
    .fiber_link_up(fiber_link_up), .far_copper_link_up(far_copper_link_up),
    .run_active(run_active), .reply_pending(reply_pending), .ctrl(ctrl));

`default_nettype wire
